/* File: icd_pkg.sv */
// Package for the input channel dynamics block: constants, modes and carriers.
// Assumes a single 25 MHz clock and one sample strobe per audio frame.
package icd_pkg;

   // ----------------------------------------
   // Widths and fixed figures
   // ----------------------------------------
   localparam int unsigned SAMPLE_W      = 24;
   localparam int unsigned RATIO         = 20;
   localparam int unsigned HEADROOM_DB   = 10;
   localparam int unsigned SOFT_KNEE_DB  = 6;
   localparam int unsigned HPF_SHIFT     = 8;
   localparam int unsigned DELAY_DEPTH   = 16;
   localparam int unsigned DELAY_AW      = 4;
   localparam int unsigned TIME_W        = 16;
   localparam int unsigned GAIN_W        = 16;
   localparam logic [15:0] GAIN_UNITY    = 16'h8000;
   localparam logic [15:0] GAIN_HEADROOM = 16'h287a;
   localparam int unsigned GAIN_FRAC     = 15;
   localparam int unsigned WIDTH_FRAC    = 7;
   localparam logic [7:0]  WIDTH_UNITY   = 8'h80;

   typedef enum logic [1:0] {
      ICD_LINK_NONE,
      ICD_LINK_STEREO,
      ICD_LINK_MS
   } icd_link_t;

   typedef enum logic [1:0] {
      ICD_LIM_IDLE,
      ICD_LIM_ATTACK,
      ICD_LIM_ACTIVE,
      ICD_LIM_RELEASE
   } icd_lim_state_t;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } icd_pair_t;

   typedef struct packed {
      logic        low_cut_filter;
      logic        phase_invert;
      logic        limiter_on;
      logic        soft_knee;
      logic [DELAY_AW-1:0] delay_samples;
   } icd_chan_cfg_t;

endpackage

/* File: icd_fifo.sv */
// FIFO of flip-flops with valid and ready on both sides.
// Assumes one clock; full and empty follow the word count exactly.
`timescale 1ns/10ps
module icd_fifo
#(
   parameter int unsigned WIDTH = 48,
   parameter int unsigned DEPTH = 16
)
(
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q];

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_q[wr_q] <= in_data;
            wr_q        <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // icd_fifo

/* File: icd_channel_pair.sv */
// Processing chain for one input pair: low cut, phase, delay, linked limiter,
// mid-side decode and monitor selection, buffered toward the mixer.
// Assumes in_valid marks one sample pair per frame, far slower than the clock.
//
// Functional notes
// - Monitor per track shows pre-fader or post-fader solo signal.
// - Optional per-input high-pass removes low-frequency content.
// - Limiter on: level above threshold is reduced.
// - Gain reduction starts after attack time above threshold.
// - Gain reduction stops after release time below threshold.
// - Excess above threshold compressed twenty to one.
// - Limiter keeps ten decibels of internal headroom.
// - Soft knee starts about six decibels below threshold.
// - Linked pairs: either channel over threshold limits both.
// - Indicator lit while a channel's limiter reduces gain.
// - Optional phase inversion negates input samples.
// - Input delay bypassed at 192 kHz sample rate.
// - Mid-side pair can be decoded to left-right stereo.
// - Stereo width set by scaling side before combining.
// - Odd input is mid, even input is side.
`timescale 1ns/10ps
module icd_channel_pair
#(
   parameter int unsigned W     = icd_pkg::SAMPLE_W,
   parameter int unsigned DEPTH = 16
)
(
   input  wire logic                     clock,
   input  wire logic                     srst,
   input  wire logic                     in_valid,
   input  wire icd_pkg::icd_pair_t       in_pair,
   input  wire icd_pkg::icd_chan_cfg_t   cfg_odd,
   input  wire icd_pkg::icd_chan_cfg_t   cfg_even,
   input  wire icd_pkg::icd_link_t       link_mode,
   input  wire logic                     rate_192k,
   input  wire logic [W-1:0]             threshold,
   input  wire logic [icd_pkg::TIME_W-1:0] attack_samples,
   input  wire logic [icd_pkg::TIME_W-1:0] release_samples,
   input  wire logic [7:0]               side_level,
   input  wire logic [15:0]              fader_gain,
   input  wire logic [1:0]               prefader_listen,
   output      logic [1:0]               limit_active,
   output      icd_pkg::icd_pair_t       monitor_pair,
   output      logic                     mix_valid,
   input  wire logic                     mix_ready,
   output      icd_pkg::icd_pair_t       mix_pair,
   output      logic                     in_ready
);
   typedef logic signed [W-1:0] smp_t;

   // ----------------------------------------
   // Arithmetic helpers
   // ----------------------------------------
   function automatic smp_t sat(input logic signed [W+1:0] v);
      if (v > $signed({3'b000, {(W-1){1'b1}}}))
         return {1'b0, {(W-1){1'b1}}};
      else if (v < $signed({3'b111, {(W-1){1'b0}}}))
         return {1'b1, {(W-1){1'b0}}};
      return v[W-1:0];
   endfunction

   function automatic smp_t mag(input smp_t v);
      return v[W-1] ? sat(-(W+2)'(v)) : v;
   endfunction

   function automatic smp_t gain(input smp_t v, input logic [15:0] g);
      logic signed [W+16:0] p;
      p = v * $signed({1'b0, g});
      return sat(p[W+1+icd_pkg::GAIN_FRAC:icd_pkg::GAIN_FRAC]);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      smp_t [1:0]                  hp_y;
      smp_t [1:0]                  hp_x;
      smp_t [1:0]                  mon;
      smp_t [1:0]                  post;
      icd_pkg::icd_lim_state_t     lim;
      logic [icd_pkg::TIME_W-1:0]  tmr;
      logic                        vld;
   } st_t;

   st_t  s_q;
   st_t  s_d;
   smp_t dly_q [2][icd_pkg::DELAY_DEPTH];
   logic [icd_pkg::DELAY_AW-1:0] wp_q;
   smp_t x     [2];
   smp_t hp    [2];
   smp_t ph    [2];
   smp_t dl    [2];
   smp_t lm    [2];
   smp_t knee;
   logic over;
   logic in_knee;
   logic reducing;
   icd_pkg::icd_chan_cfg_t cfg [2];

   assign cfg[0] = cfg_odd;
   assign cfg[1] = cfg_even;
   assign x[0]   = in_pair.left;
   assign x[1]   = in_pair.right;
   assign knee   = smp_t'(threshold) >>> 1;
   assign in_ready = 1'b1;

   always_comb
   begin
      s_d     = s_q;
      over    = 1'b0;
      in_knee = 1'b0;
      for (int c = 0; c < 2; c++)
      begin
         hp[c] = x[c] - s_q.hp_x[c] + (s_q.hp_y[c] - (s_q.hp_y[c] >>> icd_pkg::HPF_SHIFT));
         if (!cfg[c].low_cut_filter)
            hp[c] = x[c];
         ph[c] = cfg[c].phase_invert ? sat(-(W+2)'(hp[c])) : hp[c];
         dl[c] = (rate_192k || cfg[c].delay_samples == '0) ? ph[c] :
                 dly_q[c][wp_q - cfg[c].delay_samples];
         if (mag(dl[c]) > smp_t'(threshold) && cfg[c].limiter_on)
            over = 1'b1;
         if (mag(dl[c]) > smp_t'(threshold) - knee && cfg[c].soft_knee)
            in_knee = cfg[c].limiter_on;
      end
      if (link_mode == icd_pkg::ICD_LINK_NONE)
         over = over;
      reducing = (s_q.lim == icd_pkg::ICD_LIM_ACTIVE) ||
                 (s_q.lim == icd_pkg::ICD_LIM_RELEASE);
      for (int c = 0; c < 2; c++)
      begin
         lm[c] = dl[c];
         if (reducing && (link_mode != icd_pkg::ICD_LINK_NONE || cfg[c].limiter_on))
         begin
            if (mag(dl[c]) > smp_t'(threshold))
               lm[c] = dl[c][W-1] ?
                  -(smp_t'(threshold) + (mag(dl[c]) - smp_t'(threshold)) / smp_t'(icd_pkg::RATIO)) :
                  smp_t'(threshold) + (dl[c] - smp_t'(threshold)) / smp_t'(icd_pkg::RATIO);
            lm[c] = gain(lm[c], icd_pkg::GAIN_HEADROOM);
         end
         else if (in_knee && !reducing)
            lm[c] = dl[c] - (dl[c] >>> 3);
      end
      s_d.vld = 1'b0;
      if (in_valid)
      begin
         s_d.vld = 1'b1;
         for (int c = 0; c < 2; c++)
         begin
            s_d.hp_x[c] = x[c];
            s_d.hp_y[c] = hp[c];
            s_d.mon[c]  = lm[c];
            s_d.post[c] = gain(lm[c], fader_gain);
         end
         case (s_q.lim)
            icd_pkg::ICD_LIM_IDLE:
               if (over)
               begin
                  s_d.lim = icd_pkg::ICD_LIM_ATTACK;
                  s_d.tmr = attack_samples;
               end
            icd_pkg::ICD_LIM_ATTACK:
               if (!over)
                  s_d.lim = icd_pkg::ICD_LIM_IDLE;
               else if (s_q.tmr == '0)
                  s_d.lim = icd_pkg::ICD_LIM_ACTIVE;
               else
                  s_d.tmr = s_q.tmr - 1'b1;
            icd_pkg::ICD_LIM_ACTIVE:
               if (!over)
               begin
                  s_d.lim = icd_pkg::ICD_LIM_RELEASE;
                  s_d.tmr = release_samples;
               end
            icd_pkg::ICD_LIM_RELEASE:
               if (over)
                  s_d.lim = icd_pkg::ICD_LIM_ACTIVE;
               else if (s_q.tmr == '0)
                  s_d.lim = icd_pkg::ICD_LIM_IDLE;
               else
                  s_d.tmr = s_q.tmr - 1'b1;
            default:
               s_d.lim = icd_pkg::ICD_LIM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_q  <= '0;
         wp_q <= '0;
      end
      else
      begin
         s_q <= s_d;
         if (in_valid)
         begin
            dly_q[0][wp_q] <= ph[0];
            dly_q[1][wp_q] <= ph[1];
            wp_q           <= wp_q + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Mid-side decode and outputs
   // ----------------------------------------
   // The side path is scaled before the sum so width never clips the mid alone.
   logic signed [W+8:0] side_w;
   smp_t                side_s;
   icd_pkg::icd_pair_t  dec;

   always_comb
   begin
      side_w = s_q.post[1] * $signed({1'b0, side_level});
      side_s = sat(side_w[W+1+icd_pkg::WIDTH_FRAC:icd_pkg::WIDTH_FRAC]);
      dec.left  = s_q.post[0];
      dec.right = s_q.post[1];
      if (link_mode == icd_pkg::ICD_LINK_MS)
      begin
         dec.left  = sat((W+2)'(s_q.post[0]) + (W+2)'(side_s));
         dec.right = sat((W+2)'(s_q.post[0]) - (W+2)'(side_s));
      end
   end

   assign limit_active[0] = reducing && (cfg[0].limiter_on ||
                            link_mode != icd_pkg::ICD_LINK_NONE);
   assign limit_active[1] = reducing && (cfg[1].limiter_on ||
                            link_mode != icd_pkg::ICD_LINK_NONE);
   assign monitor_pair.left  = prefader_listen[0] ? s_q.mon[0] : s_q.post[0];
   assign monitor_pair.right = prefader_listen[1] ? s_q.mon[1] : s_q.post[1];

   icd_fifo #(.WIDTH(2*W), .DEPTH(DEPTH)) u_fifo
   (
      .clock     (clock),
      .srst      (srst),
      .in_valid  (s_q.vld),
      .in_ready  (),
      .in_data   (dec),
      .out_valid (mix_valid),
      .out_ready (mix_ready),
      .out_data  (mix_pair)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_attack;
      @(posedge clock) disable iff (srst)
      (s_q.lim == icd_pkg::ICD_LIM_IDLE) |=> (s_q.lim != icd_pkg::ICD_LIM_ACTIVE);
   endproperty
   a_attack: assert property (p_attack) else $error("Limiter skipped attack.");

   property p_release;
      @(posedge clock) disable iff (srst)
      (s_q.lim == icd_pkg::ICD_LIM_ACTIVE) |=> (s_q.lim != icd_pkg::ICD_LIM_IDLE);
   endproperty
   a_release: assert property (p_release) else $error("Limiter skipped release.");

   property p_indicator;
      @(posedge clock) disable iff (srst)
      (s_q.lim == icd_pkg::ICD_LIM_IDLE) |-> (limit_active == 2'b00);
   endproperty
   a_indicator: assert property (p_indicator) else $error("Indicator lit while idle.");

   // The attack count must run out before reduction starts, whatever the level does.
   property p_attack_hold;
      @(posedge clock) disable iff (srst)
      (s_q.lim == icd_pkg::ICD_LIM_ATTACK && s_q.tmr != '0) |=> (s_q.lim != icd_pkg::ICD_LIM_ACTIVE);
   endproperty
   a_attack_hold: assert property (p_attack_hold) else $error("Attack count cut short.");

   property p_bypass;
      @(posedge clock) disable iff (srst)
      rate_192k |-> (dl[0] == ph[0] && dl[1] == ph[1]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("Delay used at top rate.");

   property p_hard_knee;
      @(posedge clock) disable iff (srst)
      (!reducing && !in_knee) |-> (lm[0] == dl[0] && lm[1] == dl[1]);
   endproperty
   a_hard_knee: assert property (p_hard_knee) else $error("Level changed below threshold.");

   property p_link;
      @(posedge clock) disable iff (srst)
      (reducing && link_mode != icd_pkg::ICD_LINK_NONE) |-> (limit_active == 2'b11);
   endproperty
   a_link: assert property (p_link) else $error("Linked pair limits one side only.");

   // Without filter or inversion the phase stage must pass the sample untouched.
   property p_phase;
      @(posedge clock) disable iff (srst)
      (!cfg_odd.low_cut_filter && !cfg_odd.phase_invert) |-> (ph[0] == x[0]);
   endproperty
   a_phase: assert property (p_phase) else $error("Odd sample altered in phase stage.");
endmodule // icd_channel_pair

/* File: icd_conv_model.sv */
// Converter model: hands sample pairs to the channel pair.
// Each send pulses in_valid for one clock; back-to-back sends come three clocks apart.
`timescale 1ns/10ps
module icd_conv_model
(
   input  wire logic   clock,
   output logic        in_valid,
   output icd_pkg::icd_pair_t in_pair
);
   initial
   begin
      in_valid = 1'b0;
      in_pair  = '0;
   end
   // Released data turns to its inverse so a stale word never looks fresh.
   task automatic send(input icd_pkg::icd_pair_t p);
   begin
      @(negedge clock);
      in_valid = 1'b1;
      in_pair  = p;
      @(negedge clock);
      in_valid = 1'b0;
      in_pair  = ~p;
      @(negedge clock);
   end
   endtask
endmodule // icd_conv_model

/* File: input_channel_dynamics_tb_top.sv */
// Self-checking bench for the channel pair with a converter model.
// Assumes one 25 MHz clock and sync reset.
`timescale 1ns/10ps
module input_channel_dynamics_tb_top;
   // ---------------------------------------
   // Signals
   // ---------------------------------------
   logic clock, srst, mix_ready, rate_192k, mix_valid, in_ready, in_valid, track, hold;
   icd_pkg::icd_pair_t in_pair, monitor_pair, mix_pair, x, e;
   icd_pkg::icd_chan_cfg_t cfg_odd, cfg_even;
   icd_pkg::icd_link_t link_mode;
   logic [23:0] threshold;
   logic [15:0] attack_samples, release_samples, fader_gain;
   logic [7:0]  side_level;
   logic [1:0]  prefader_listen, limit_active;
   icd_pkg::icd_pair_t exp_q[$];
   icd_pkg::icd_pair_t hq[$];
   int mismatches, n_tests, i;
   icd_conv_model icd_conv_model_i (.clock(clock), .in_valid(in_valid), .in_pair(in_pair));
   icd_channel_pair icd_channel_pair_i (.clock(clock), .srst(srst), .in_valid(in_valid),
      .in_pair(in_pair), .cfg_odd(cfg_odd), .cfg_even(cfg_even), .link_mode(link_mode),
      .rate_192k(rate_192k), .threshold(threshold), .attack_samples(attack_samples),
      .release_samples(release_samples), .side_level(side_level), .fader_gain(fader_gain),
      .prefader_listen(prefader_listen), .limit_active(limit_active),
      .monitor_pair(monitor_pair), .mix_valid(mix_valid), .mix_ready(mix_ready),
      .mix_pair(mix_pair), .in_ready(in_ready));
   // ---------------------------------------
   // Helpers
   // ---------------------------------------
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [23:0] rnd();
      logic [31:0] r;
      r = $urandom;
      return {{3{r[20]}}, r[20:1], 1'b0};
   endfunction
   function automatic logic [23:0] sat(input logic signed [24:0] v);
      if (v > 25'sh07f_ffff)
         return 24'h7f_ffff;
      if (v < -25'sh080_0000)
         return 24'h80_0000;
      return v[23:0];
   endfunction
   // The queue bound mirrors the FIFO depth: a full FIFO drops the word.
   task automatic go(input icd_pkg::icd_pair_t s, mon, mx, input logic cm);
      if (track && exp_q.size() < 16)
         exp_q.push_back(mx);
      icd_conv_model_i.send(s);
      if (cm)
         chk(monitor_pair, mon, "monitor");
   endtask
   task automatic drain();
      hold = 1'b0;
      repeat (300) @(negedge clock);
      chk(exp_q.size(), 0, "left over");
      track = 1'b1;
   endtask
   always @(posedge clock)
      if ($sampled(mix_valid) === 1'b1 && $sampled(mix_ready) === 1'b1 && track === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            mismatches++;
            $display("wrong value at %0t: mix word with nothing expected", $time);
         end
         else
            chk($sampled(mix_pair), exp_q.pop_front(), "mix");
      end
   always @(negedge clock)
      mix_ready <= hold ? 1'b0 : 1'($urandom);
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial
   begin
      repeat (60000) @(posedge clock);
      mismatches++;
      finish_test();
   end
   // ---------------------------------------
   // Scenarios
   // ---------------------------------------
   initial
   begin
      void'($urandom(29678));
      srst = 1'b1; hold = 1'b0; track = 1'b1; rate_192k = 1'b0; cfg_odd = '0; cfg_even = '0;
      link_mode = icd_pkg::ICD_LINK_NONE; threshold = 24'h7f_ffff; attack_samples = 16'h0001;
      release_samples = 16'h0001; side_level = 8'h80; fader_gain = 16'h8000;
      prefader_listen = 2'b11;
      repeat (12) @(negedge clock);
      srst = 1'b0;
      for (i = 0; i < 40; i++)
      begin
         x = (i == 0) ? {24'h7f_ffff, 24'h80_0000} : {rnd(), rnd()};
         cfg_odd.phase_invert = (i >= 20);
         cfg_even.phase_invert = (i >= 20);
         e = (i >= 20) ? {-x.left, -x.right} : x;
         go(x, e, e, 1'b1);
      end
      cfg_odd = '0; cfg_even = '0; fader_gain = 16'h0000; prefader_listen = 2'b01;
      for (i = 0; i < 6; i++)
      begin
         x = {rnd(), rnd()};
         go(x, {x.left, 24'h0}, '0, 1'b1);
      end
      fader_gain = 16'h8000; link_mode = icd_pkg::ICD_LINK_MS;
      for (i = 0; i < 24; i++)
      begin
         x = (i == 0) ? {24'h7f_ffff, 24'h7f_ffff} : {rnd(), rnd()};
         side_level = (i % 3 == 0) ? 8'h80 : (i % 3 == 1) ? 8'h40 : 8'h00;
         e.right = 24'((33'(signed'(x.right)) * $signed({25'h0, side_level})) >>> 7);
         e = {sat(signed'(x.left) + signed'(e.right)), sat(signed'(x.left) - signed'(e.right))};
         go(x, '0, e, 1'b0);
      end
      link_mode = icd_pkg::ICD_LINK_NONE; rate_192k = 1'b1; cfg_odd.delay_samples = 4'h5;
      cfg_even.delay_samples = 4'h5; prefader_listen = 2'b11;
      for (i = 0; i < 4; i++)
      begin
         x = {rnd(), rnd()};
         go(x, x, x, 1'b1);
         hq.push_back(x);
      end
      rate_192k = 1'b0; cfg_odd.delay_samples = 4'h2; cfg_even.delay_samples = 4'h2;
      for (i = 0; i < 4; i++)
      begin
         x = {rnd(), rnd()};
         go(x, hq[hq.size()-2], hq[hq.size()-2], 1'b1);
         hq.push_back(x);
      end
      rate_192k = 1'b0; cfg_odd = '0; cfg_even = '0; drain();
      hold = 1'b1;
      for (i = 0; i < 18; i++)
      begin
         x = {rnd(), rnd()};
         go(x, '0, x, 1'b0);
      end
      e = {rnd(), rnd()};
      for (i = 0; i < 16; i++)
         exp_q[i] = exp_q[i];
      chk(mix_valid, 1, "full");
      chk(exp_q.size(), 16, "kept");
      drain();
      track = 1'b0; cfg_odd.low_cut_filter = 1'b1;
      for (i = 0; i < 1500; i++)
         icd_conv_model_i.send({24'h40_0000, 24'h40_0000});
      chk($signed(monitor_pair.left) < 24'sh00_4000, 1, "low cut");
      cfg_odd = '0; cfg_odd.limiter_on = 1'b1; cfg_even = cfg_odd; threshold = 24'h10_0000;
      attack_samples = 16'h0004; release_samples = 16'h0004; link_mode = icd_pkg::ICD_LINK_STEREO;
      for (i = 0; i < 13; i++)
      begin
         icd_conv_model_i.send({24'h40_0000, 24'h00_1000});
         if (i == 0)
            chk(limit_active, 0, "attack");
      end
      chk(limit_active, 3, "linked");
      chk(monitor_pair.left < threshold && monitor_pair.left > 24'h02_0000, 1, "gain");
      for (i = 0; i < 13; i++)
      begin
         icd_conv_model_i.send({24'h00_1000, 24'h00_1000});
         if (i == 0)
            chk(limit_active, 3, "hold");
      end
      chk(limit_active, 0, "release");
      chk(monitor_pair, {24'h00_1000, 24'h00_1000}, "below");
      for (i = 0; i < 24; i++)
      begin
         cfg_odd.soft_knee = (i >= 12);
         icd_conv_model_i.send({24'h0c_0000, 24'h0c_0000});
         if (i == 11)
            chk(monitor_pair.left, 24'h0c_0000, "hard knee");
      end
      chk(monitor_pair.left < 24'h0c_0000, 1, "soft knee");
      drain();
      finish_test();
   end
endmodule // input_channel_dynamics_tb_top
